// file: core/hrs_pkg.sv
// Package for the hub reset sequencer: timing figures, cycle counts, modes.
// Assumes a single 100 MHz clock; every cycle count but PIN_SYNC_CYC is derived here from a time.
`default_nettype none
package hrs_pkg;
   localparam int CLK_MHZ = 100;
   // Times in their own units, as printed
   localparam int RECOVER_US = 500;
   localparam int STRAP_HOLD_MIN_NS_X10 = 167;
   localparam int STRAP_HOLD_MAX_NS = 1400;
   localparam int STRAP_DRIVE_MAX_US = 2;
   localparam int CFG_EEPROM_MAX_US = 99500;
   localparam int ATTACH_MAX_MS = 100;
   localparam int REQ_MAX_MS = 5;
   // Cycle counts: least times round up, longest times round down
   localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
   localparam int STRAP_SAMPLE_CYC = (STRAP_HOLD_MIN_NS_X10 * CLK_MHZ + 9999) / 10000;
   localparam int STRAP_LAST_CYC = STRAP_HOLD_MAX_NS * CLK_MHZ / 1000;
   localparam int STRAP_DRIVE_CYC = STRAP_DRIVE_MAX_US * CLK_MHZ;
   localparam int CFG_EEPROM_CYC = CFG_EEPROM_MAX_US * CLK_MHZ;
   localparam int ATTACH_CYC = ATTACH_MAX_MS * 1000 * CLK_MHZ;
   localparam int REQ_CYC = REQ_MAX_MS * 1000 * CLK_MHZ;
   localparam int NUM_PORTS = 7;
   // Edges from a pin change to the third synchroniser stage holding it
   localparam int PIN_SYNC_CYC = 3;
   localparam int CNT_W = 32;
   // Configuration source, from the two select straps
   typedef enum logic [1:0] {
      HRS_CFG_STRAP = 2'h0,
      HRS_CFG_EEPROM = 2'h1,
      HRS_CFG_SMBUS = 2'h2,
      HRS_CFG_RSVD = 2'h3
   } hrs_cfg_t;
   typedef enum logic [3:0] {
      HRS_RECOVER,
      HRS_STRAP_WAIT,
      HRS_CFG_LOAD,
      HRS_SMB_WAIT,
      HRS_ATTACH_WAIT,
      HRS_RUN
   } hrs_state_t;
endpackage : hrs_pkg
`default_nettype wire

// file: core/hrs_hub_reset_sequencer.sv
// Hub reset and start-up sequencer: recovery, configuration, attach, bus reset.
// Assumes clk runs only once the oscillator and PLL are alive; reset pin is raw.
//
// What this block does
// - During reset all downstream ports disabled and port power removed.
// - During reset transceivers off, differential pairs high impedance.
// - Reset aborts all transactions at once; no state survives.
// - Reset returns every register to its default, mostly zero.
// - During reset oscillator and PLL stopped, LED outputs disabled.
// - Device becomes operational 500 us after reset release.
// - Once operational, read EEPROM configuration only when EEPROM mode chosen.
// - Straps sampled between 16.7 ns and 1400 ns after release.
// - Strap mode drives outputs inactive within 2 us of release.
// - Strap and EEPROM modes attach within 100 ms of configuration.
// - EEPROM read and configuration finish within 99.5 ms.
// - After SMBus code load, configure and attach within 100 ms.
// - Each standard request completes within 5 ms.
// - Upstream bus reset is never forwarded downstream.
// - Bus reset sets address zero and returns to unconfigured.
// - Bus reset removes power from downstream ports seven to one.
// - Bus reset clears every transaction translator buffer; tt_clear pulses only while usb_attach is set.
// - Bus reset takes a suspended device back to active.
// - SMBus mode waits forever for code load before appearing on USB.
// - Strap mode samples LED pins after release as configuration straps.
`default_nettype none
module hrs_hub_reset_sequencer import hrs_pkg::*; #(
   parameter int RECOVER_CYCLES = hrs_pkg::RECOVER_CYC,
   parameter int CFG_TIMEOUT_CYCLES = hrs_pkg::CFG_EEPROM_CYC,
   parameter int ATTACH_CYCLES = hrs_pkg::ATTACH_CYC,
   parameter int REQ_CYCLES = hrs_pkg::REQ_CYC,
   parameter int LED_W = 2 * hrs_pkg::NUM_PORTS
) (
   // Clock and raw reset pin
   input wire logic clk,
   input wire logic rst_n,
   // Configuration select straps and LED strap pins (asynchronous pins)
   input wire logic [1:0] cfg_sel,
   input wire logic [LED_W-1:0] led_strap_in,
   // Configuration loader handshake
   input wire logic cfg_load_done,
   input wire logic smb_load_done,
   output logic eeprom_read_start,
   output logic cfg_busy,
   // Upstream USB events
   input wire logic usb_bus_reset,
   input wire logic req_start,
   input wire logic req_done,
   input wire logic suspend_req,
   // Hub state outputs
   output logic operational,
   output logic [LED_W-1:0] strap_value,
   output logic strap_valid,
   output logic outputs_drive_en,
   output logic usb_attach,
   output logic [6:0] usb_address,
   output logic configured,
   output logic suspended,
   output logic tt_clear,
   output logic [hrs_pkg::NUM_PORTS:1] port_power_enable,
   output logic [hrs_pkg::NUM_PORTS:1] port_enable,
   output logic phy_enable,
   output logic led_enable,
   output logic osc_pll_run,
   output logic req_timeout,
   output logic downstream_reset
);
   import hrs_pkg::*;

   // Elaboration checks: every timed stage needs at least one cycle
   if (RECOVER_CYCLES < 1 || CFG_TIMEOUT_CYCLES < 1 || ATTACH_CYCLES < 1 || REQ_CYCLES < 1) begin : g_bad_counts
      $error("hrs: cycle counts must be at least one");
   end
   // The strap window must leave room for the pin synchroniser
   if (STRAP_SAMPLE_CYC + PIN_SYNC_CYC > STRAP_LAST_CYC) begin : g_bad_window
      $error("hrs: strap sample window empty");
   end
   // Strap pins come in pairs, one amber and one green per port
   if (LED_W < 2 || LED_W % 2 != 0) begin : g_bad_led
      $error("hrs: strap width must be a positive even number");
   end

   // Count test used by every timed stage
   function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int lim);
      return c >= CNT_W'(lim - 1);
   endfunction

   // Strap mode test; the reserved select code behaves as strap mode
   function automatic logic is_strap_mode(input logic [1:0] s);
      return s == HRS_CFG_STRAP || s == HRS_CFG_RSVD;
   endfunction

   // Release synchroniser: assert async, release after two clean edges
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire logic srst_n = rst_sync_ff;

   // Pin inputs: three stages, a change counts when stages two and three agree
   logic [1:0] sel_s1_ff, sel_s2_ff, sel_s3_ff, sel_ff;
   logic [LED_W-1:0] led_s1_ff, led_s2_ff, led_s3_ff;
   logic [2:0] bre_s1_ff, bre_s2_ff, bre_s3_ff, ev_ff;

   // Select straps; the filtered copy only moves on two agreeing samples
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         sel_s1_ff <= '0;
         sel_s2_ff <= '0;
         sel_s3_ff <= '0;
         sel_ff <= '0;
      end else begin
         sel_s1_ff <= cfg_sel;
         sel_s2_ff <= sel_s1_ff;
         sel_s3_ff <= sel_s2_ff;
         if (sel_s2_ff == sel_s3_ff) begin
            sel_ff <= sel_s3_ff;
         end
      end
   end

   // LED strap pins; the capture below does its own agreement test
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         led_s1_ff <= '0;
         led_s2_ff <= '0;
         led_s3_ff <= '0;
      end else begin
         led_s1_ff <= led_strap_in;
         led_s2_ff <= led_s1_ff;
         led_s3_ff <= led_s2_ff;
      end
   end

   // Bus reset, code-load done and suspend; each bit filtered on its own
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         bre_s1_ff <= '0;
         bre_s2_ff <= '0;
         bre_s3_ff <= '0;
         ev_ff <= '0;
      end else begin
         bre_s1_ff <= {usb_bus_reset, smb_load_done, suspend_req};
         bre_s2_ff <= bre_s1_ff;
         bre_s3_ff <= bre_s2_ff;
         for (int i = 0; i < 3; i++) begin
            if (bre_s2_ff[i] == bre_s3_ff[i]) begin
               ev_ff[i] <= bre_s3_ff[i];
            end
         end
      end
   end
   wire logic bus_rst_lvl = ev_ff[2];
   wire logic smb_done_lvl = ev_ff[1];
   wire logic susp_lvl = ev_ff[0];
   logic bus_rst_d_ff;
   wire logic bus_rst_rise = bus_rst_lvl && !bus_rst_d_ff;
   logic susp_d_ff;
   wire logic susp_rise = susp_lvl && !susp_d_ff;

   // Start-up sequence state and its counter
   hrs_state_t state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] rel_cnt_ff;
   hrs_cfg_t mode;
   assign mode = hrs_cfg_t'(sel_ff);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         HRS_RECOVER: begin
            if (cnt_hit(cnt_ff, RECOVER_CYCLES)) begin
               if (mode == HRS_CFG_SMBUS) begin
                  nxt_state = HRS_SMB_WAIT;
               end else if (mode == HRS_CFG_EEPROM) begin
                  nxt_state = HRS_CFG_LOAD;
               end else begin
                  nxt_state = HRS_STRAP_WAIT;
               end
            end
         end
         HRS_STRAP_WAIT: nxt_state = HRS_ATTACH_WAIT;
         HRS_CFG_LOAD: begin
            // Timeout stands in for a missing EEPROM so attach is still met
            if (cfg_load_done || cnt_hit(cnt_ff, CFG_TIMEOUT_CYCLES)) begin
               nxt_state = HRS_ATTACH_WAIT;
            end
         end
         HRS_SMB_WAIT: begin
            if (smb_done_lvl) begin
               nxt_state = HRS_ATTACH_WAIT;
            end
         end
         HRS_ATTACH_WAIT: begin
            // Attach once configuration settles; bounded at the 100 ms limit itself
            if (!cfg_busy || cnt_hit(cnt_ff, ATTACH_CYCLES)) begin
               nxt_state = HRS_RUN;
            end
         end
         HRS_RUN: nxt_state = HRS_RUN;
         default: nxt_state = HRS_RECOVER;
      endcase
   end

   // Sequence registers; synchronous release restarts everything from zero
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         state_ff <= HRS_RECOVER;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= (nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
      end
   end

   // Time since release, saturating, for strap window and output drive
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         rel_cnt_ff <= '0;
      end else if (rel_cnt_ff < CNT_W'(STRAP_DRIVE_CYC)) begin
         rel_cnt_ff <= rel_cnt_ff + 1'b1;
      end
   end

   // Strap capture inside the hold window after release. Pins are taken only
   // once the synchroniser holds them and two stages agree, so the reset
   // value of the stages is never mistaken for a strap level
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         strap_value <= '0;
         strap_valid <= 1'b0;
      end else if (!strap_valid && rel_cnt_ff >= CNT_W'(STRAP_SAMPLE_CYC + PIN_SYNC_CYC)
                   && rel_cnt_ff <= CNT_W'(STRAP_LAST_CYC)
                   && led_s2_ff == led_s3_ff && sel_s2_ff == sel_s3_ff) begin
         strap_value <= led_s3_ff;
         strap_valid <= is_strap_mode(sel_s3_ff);
      end
   end

   // Outputs driven inactive well before the 2 us bound
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         outputs_drive_en <= 1'b0;
         osc_pll_run <= 1'b0;
      end else begin
         osc_pll_run <= 1'b1;
         if (rel_cnt_ff >= CNT_W'(STRAP_LAST_CYC)) begin
            outputs_drive_en <= 1'b1;
         end
      end
   end

   // Loader handshake, attach and operational flags
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         operational <= 1'b0;
         eeprom_read_start <= 1'b0;
         cfg_busy <= 1'b0;
         usb_attach <= 1'b0;
         phy_enable <= 1'b0;
         led_enable <= 1'b0;
      end else begin
         // Operational rises with the loader start, never after it
         operational <= nxt_state != HRS_RECOVER;
         eeprom_read_start <= state_ff == HRS_RECOVER && nxt_state == HRS_CFG_LOAD;
         cfg_busy <= nxt_state == HRS_CFG_LOAD || nxt_state == HRS_SMB_WAIT;
         usb_attach <= nxt_state == HRS_RUN;
         phy_enable <= nxt_state == HRS_RUN;
         led_enable <= state_ff != HRS_RECOVER;
      end
   end

   // USB device state: bus reset clears address, configuration and suspend
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         bus_rst_d_ff <= 1'b0;
         susp_d_ff <= 1'b0;
         usb_address <= '0;
         configured <= 1'b0;
         suspended <= 1'b0;
         tt_clear <= 1'b0;
      end else begin
         bus_rst_d_ff <= bus_rst_lvl;
         susp_d_ff <= susp_lvl;
         tt_clear <= bus_rst_rise && usb_attach;
         if (bus_rst_rise) begin
            usb_address <= '0;
            configured <= 1'b0;
            suspended <= 1'b0;
         end else if (susp_rise && usb_attach) begin
            suspended <= 1'b1; // Only a fresh request suspends again
         end else if (!susp_lvl) begin
            suspended <= 1'b0;
         end
      end
   end

   // Port power and enables are only ever cleared here; bus reset and detach drop them
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         port_power_enable <= '0;
         port_enable <= '0;
      end else if (bus_rst_rise || !usb_attach) begin
         port_power_enable <= '0;
         port_enable <= '0;
      end
   end
   // Upstream reset never reaches the downstream ports
   assign downstream_reset = 1'b0;

   // Standard request watchdog; flags a request running past its bound
   logic [CNT_W-1:0] req_cnt_ff;
   logic req_busy_ff;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         req_busy_ff <= 1'b0;
         req_cnt_ff <= '0;
         req_timeout <= 1'b0;
      end else begin
         req_timeout <= 1'b0;
         if (bus_rst_rise || req_done) begin
            req_busy_ff <= 1'b0;
         end else if (req_start && usb_attach) begin
            req_busy_ff <= 1'b1;
            req_cnt_ff <= '0;
         end else if (req_busy_ff) begin
            req_cnt_ff <= req_cnt_ff + 1'b1;
            if (cnt_hit(req_cnt_ff, REQ_CYCLES)) begin
               req_timeout <= 1'b1;
               req_busy_ff <= 1'b0;
            end
         end
      end
   end
endmodule : hrs_hub_reset_sequencer
`default_nettype wire

// file: bench/hrs_cfg_host.sv
// Model of the configuration sources: EEPROM loader and SMBus code-load host.
// Assumes the bench sets both delays while reset is held; zero means no answer.
`default_nettype none
module hrs_cfg_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Hub side
   input wire logic eeprom_read_start,
   input wire logic operational,
   output logic cfg_load_done,
   output logic smb_load_done,
   // Bench controls, in clock cycles
   input wire logic [15:0] ack_dly,
   input wire logic [15:0] smb_dly
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] ecnt;
   logic [15:0] scnt;
   // Answers change only just after a falling edge, like every bench driver
   always @(negedge clk) begin
      if (!rst_n) begin
         ecnt <= 16'h0;
         scnt <= 16'h0;
         cfg_load_done <= 1'b0;
         smb_load_done <= 1'b0;
      end else begin
         cfg_load_done <= ecnt == 16'h1;
         if (eeprom_read_start && ack_dly != 16'h0) ecnt <= ack_dly;
         else if (ecnt != 16'h0) ecnt <= ecnt - 16'h1;
         if (operational && !smb_load_done) scnt <= scnt + 16'h1;
         if (smb_dly != 16'h0 && scnt == smb_dly) smb_load_done <= 1'b1;
      end
   end
endmodule // hrs_cfg_host
`default_nettype wire

// file: bench/hrs_sva.sv
// Checker for the hub reset sequencer: reset quiet state, start-up, bus reset.
// Assumes the bind below hands on the shortened counts of the sequencer.
`default_nettype none
module hrs_sva import hrs_pkg::*; #(
   parameter int RECOVER_CYCLES = 50,
   parameter int CFG_TIMEOUT_CYCLES = 200,
   parameter int ATTACH_CYCLES = 100
) (
   // Clock, reset and inputs
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] cfg_sel,
   input wire logic smb_load_done,
   input wire logic usb_bus_reset,
   // Outputs watched
   input wire logic eeprom_read_start,
   input wire logic cfg_busy,
   input wire logic operational,
   input wire logic strap_valid,
   input wire logic outputs_drive_en,
   input wire logic usb_attach,
   input wire logic [6:0] usb_address,
   input wire logic configured,
   input wire logic suspended,
   input wire logic tt_clear,
   input wire logic [hrs_pkg::NUM_PORTS:1] port_power_enable,
   input wire logic [hrs_pkg::NUM_PORTS:1] port_enable,
   input wire logic phy_enable,
   input wire logic led_enable,
   input wire logic osc_pll_run,
   input wire logic downstream_reset
);
   localparam int CFG_MAX = CFG_TIMEOUT_CYCLES + 8;
   localparam int ATT_MAX = ATTACH_CYCLES + 8;
   logic [15:0] cnt_ff;
   logic strap_mode;
   assign strap_mode = (cfg_sel == 2'h0) || (cfg_sel == 2'h3);
   // Edges since release; saturates so late checks never wrap round
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_ff <= 16'h0;
      else if (cnt_ff != 16'hffff) cnt_ff <= cnt_ff + 16'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rst_ports; disable iff (1'b0) !rst_n |-> port_enable == '0 && port_power_enable == '0; endproperty
   a_rst_ports: assert property (p_rst_ports) else $error("ports live in reset");
   property p_rst_off; disable iff (1'b0) !rst_n |-> !phy_enable && !osc_pll_run && !led_enable; endproperty
   a_rst_off: assert property (p_rst_off) else $error("phy or clock live in reset");
   property p_rst_state; disable iff (1'b0) !rst_n |-> !usb_attach && !cfg_busy && usb_address == 7'h0; endproperty
   a_rst_state: assert property (p_rst_state) else $error("state kept in reset");
   property p_recover; cnt_ff == RECOVER_CYCLES + 6 |-> operational; endproperty
   a_recover: assert property (p_recover) else $error("late operational");
   property p_rd_pulse; eeprom_read_start |-> operational && cfg_sel != 2'h2 ##1 !eeprom_read_start; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("bad loader start");
   property p_strap; strap_mode && cnt_ff == 16'd141 |-> strap_valid; endproperty
   a_strap: assert property (p_strap) else $error("strap not sampled");
   property p_drive; strap_mode && cnt_ff == 16'd200 |-> outputs_drive_en; endproperty
   a_drive: assert property (p_drive) else $error("outputs not driven");
   property p_cfg_end; $rose(cfg_busy) && cfg_sel == 2'h1 |-> ##[1:CFG_MAX] !cfg_busy; endproperty
   a_cfg_end: assert property (p_cfg_end) else $error("load never ends");
   property p_attach; $fell(cfg_busy) |-> ##[0:ATT_MAX] usb_attach; endproperty
   a_attach: assert property (p_attach) else $error("late attach");
   property p_smb_hold; (cfg_sel == 2'h2 && !smb_load_done) [*4] |-> !usb_attach; endproperty
   a_smb_hold: assert property (p_smb_hold) else $error("attach before code load");
   property p_busrst;
      $rose(usb_bus_reset) |-> ##[1:8] (tt_clear && !suspended && !configured && usb_address == 7'h0
         && port_power_enable == '0);
   endproperty
   a_busrst: assert property (p_busrst) else $error("bad bus reset");
   property p_no_fwd; !downstream_reset; endproperty
   a_no_fwd: assert property (p_no_fwd) else $error("bus reset forwarded");
   c_oper: cover property ($rose(operational));
   c_attach: cover property ($rose(usb_attach));
   c_busrst: cover property (tt_clear);
endmodule // hrs_sva
bind hrs_hub_reset_sequencer hrs_sva #(.RECOVER_CYCLES(RECOVER_CYCLES), .CFG_TIMEOUT_CYCLES(CFG_TIMEOUT_CYCLES),
   .ATTACH_CYCLES(ATTACH_CYCLES)) u_sva (.clk, .rst_n, .cfg_sel, .smb_load_done, .usb_bus_reset,
   .eeprom_read_start, .cfg_busy, .operational, .strap_valid, .outputs_drive_en, .usb_attach, .usb_address,
   .configured, .suspended, .tt_clear, .port_power_enable, .port_enable, .phy_enable, .led_enable,
   .osc_pll_run, .downstream_reset);
`default_nettype wire

// file: bench/test_hub_reset_sequencer.sv
// Self-checking bench for the hub reset sequencer, counts shortened.
// Assumes hrs_cfg_host answers the loaders and hrs_sva is bound to uut.
`default_nettype none
module test_hub_reset_sequencer import hrs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int REC = 50;
   localparam int CFGT = 200;
   localparam int ATT = 100;
   localparam int REQ = 100;
   logic clk = 1'b1;
   logic rst_n = 1'b1;
   logic [1:0] cfg_sel;
   logic [13:0] led_strap_in, strap_value;
   logic cfg_load_done, smb_load_done, eeprom_read_start, cfg_busy, usb_bus_reset, req_start, req_done;
   logic suspend_req, operational, strap_valid, outputs_drive_en, usb_attach, configured, suspended;
   logic tt_clear, phy_enable, led_enable, osc_pll_run, req_timeout, downstream_reset, rd_seen;
   logic [6:0] usb_address;
   logic [7:1] port_power_enable, port_enable;
   logic [15:0] ack_dly, smb_dly;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int to_cnt = 0;
   int n;
   hrs_hub_reset_sequencer #(.RECOVER_CYCLES(REC), .CFG_TIMEOUT_CYCLES(CFGT), .ATTACH_CYCLES(ATT),
      .REQ_CYCLES(REQ)) uut (.clk, .rst_n, .cfg_sel, .led_strap_in, .cfg_load_done, .smb_load_done,
      .eeprom_read_start, .cfg_busy, .usb_bus_reset, .req_start, .req_done, .suspend_req, .operational,
      .strap_value, .strap_valid, .outputs_drive_en, .usb_attach, .usb_address, .configured, .suspended,
      .tt_clear, .port_power_enable, .port_enable, .phy_enable, .led_enable, .osc_pll_run, .req_timeout,
      .downstream_reset);
   hrs_cfg_host u_host (.clk, .rst_n, .eeprom_read_start, .operational, .cfg_load_done, .smb_load_done,
      .ack_dly, .smb_dly);
   always #5 clk = ~clk;
   // Cycle ceiling, pulse tallies and loader-start memory
   always @(posedge clk) begin
      cyc++;
      if (req_timeout === 1'b1) to_cnt++;
      rd_seen <= !rst_n ? 1'b0 : (rd_seen | eeprom_read_start);
      if (cyc == 12000) begin
         num_errors++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset held past its minimum width; outputs must be quiet meanwhile
   task automatic do_reset(input logic [1:0] mode);
      @(negedge clk);
      rst_n = 1'b0;
      cfg_sel = mode;
      repeat (100) @(negedge clk);
      chk({port_enable, port_power_enable}, 32'h0);
      chk({phy_enable, osc_pll_run, led_enable}, 32'h0);
      chk({usb_attach, cfg_busy, operational, usb_address}, 32'h0);
      rst_n = 1'b1;
   endtask
   task automatic t_strap(input logic [1:0] mode);
      led_strap_in = 14'h2a5b;
      do_reset(mode);
      @(negedge clk);
      chk(strap_valid, 1'b0);
      repeat (149) @(negedge clk);
      led_strap_in = 14'h15a4;
      chk({strap_valid, strap_value}, {1'b1, 14'h2a5b});
      repeat (50) @(negedge clk);
      chk({outputs_drive_en, operational, phy_enable, led_enable, osc_pll_run}, 5'h1f);
      for (n = 0; n < ATT + 20 && usb_attach !== 1'b1; n++) @(negedge clk);
      chk(usb_attach, 1'b1);
      $display("strap test done");
   endtask
   task automatic t_req;
      n = to_cnt;
      req_start = 1'b1;
      @(negedge clk);
      req_start = 1'b0;
      repeat (REQ + 10) @(negedge clk);
      chk(to_cnt - n, 1);
      req_start = 1'b1;
      @(negedge clk);
      req_start = 1'b0;
      req_done = 1'b1;
      @(negedge clk);
      req_done = 1'b0;
      n = to_cnt;
      repeat (REQ + 10) @(negedge clk);
      chk(to_cnt - n, 0);
      $display("request test done");
   endtask
   task automatic t_eeprom(input logic mute);
      ack_dly = mute ? 16'h0 : 16'd40;
      do_reset(2'h1);
      for (n = 0; n < REC + 10 && eeprom_read_start !== 1'b1; n++) @(negedge clk);
      chk({operational, eeprom_read_start}, 2'h3);
      @(negedge clk);
      chk(cfg_busy, 1'b1);
      for (n = 0; n < CFGT + 10 && cfg_busy !== 1'b0; n++) @(negedge clk);
      chk(cfg_busy, 1'b0);
      for (n = 0; n < ATT + 10 && usb_attach !== 1'b1; n++) @(negedge clk);
      chk({usb_attach, strap_valid}, 2'h2);
      $display("loader test done, mute=%0d", mute);
   endtask
   task automatic t_smb;
      smb_dly = 16'd300;
      do_reset(2'h2);
      repeat (REC + 250) @(negedge clk);
      chk({operational, rd_seen, usb_attach}, 3'h4);
      for (n = 0; n < ATT + 120 && usb_attach !== 1'b1; n++) @(negedge clk);
      chk(usb_attach, 1'b1);
      $display("code load test done");
   endtask
   // Host suspends the hub, waits out its settle time, then resets the bus
   task automatic t_busrst;
      suspend_req = 1'b1;
      repeat (ATT) @(negedge clk);
      chk(suspended, 1'b1);
      usb_bus_reset = 1'b1;
      for (n = 0; n < 8 && tt_clear !== 1'b1; n++) @(negedge clk);
      chk({tt_clear, suspended, configured, usb_address, port_power_enable, downstream_reset}, 18'h20000);
      repeat (4) @(negedge clk);
      chk(suspended, 1'b0);
      usb_bus_reset = 1'b0;
      suspend_req = 1'b0;
      $display("bus reset test done");
   endtask
   initial begin
      {usb_bus_reset, req_start, req_done, suspend_req} = 4'h0;
      cfg_sel = 2'h0;
      led_strap_in = 14'h0;
      ack_dly = 16'd40;
      smb_dly = 16'h0;
      t_strap(2'h3);
      t_strap(2'h0);
      t_req;
      t_eeprom(1'b0);
      t_eeprom(1'b1);
      t_smb;
      t_busrst;
      do_reset(2'h1);
      stop_test;
   end
endmodule // test_hub_reset_sequencer
`default_nettype wire
